// ==== design/wrb_defines.svh ====
// offsets, field positions, reset values and timing figures of the backscatter control block
`ifndef WRB_DEFINES_SVH
`define WRB_DEFINES_SVH

`define WRB_CLK_MHZ         200
`define WRB_BIT_PERIOD_US   500
`define WRB_SENSE_READ_MS   24
`define WRB_PRIO_PERIOD_MS  35
`define WRB_STD_PERIOD_MS   235
`define WRB_DEGLITCH_US     10

`define WRB_ADR_CTRL        8'h00
`define WRB_ADR_STATUS      8'h04
`define WRB_ADR_BUF         8'h08
`define WRB_ADR_ILIM        8'h0c

`define WRB_CTRL_GO         0
`define WRB_CTRL_REPORT     1
`define WRB_CTRL_PRIO       2
`define WRB_CTRL_SDCLR      3
`define WRB_CTRL_LEN_LSB    8
`define WRB_CTRL_HDR_LSB    16
`define WRB_ST_RSN_LSB      8
`define WRB_ST_ILIM_EN      16
`define WRB_ST_STROBE       17

`define WRB_LEN_RST         5'h00
`define WRB_HDR_RST         8'h00

`define WRB_HDR_REPORT      8'h04
`define WRB_HDR_EPT         8'h02
`define WRB_RSN_UNKNOWN     8'h00
`define WRB_RSN_OVERTEMP    8'h03
`define WRB_EPT_CHARS       6'h03
`define WRB_CHAR_LAST_BIT   4'ha

`define WRB_ILIM_KNEE_MA    12'h12c
`define WRB_ILIM_FIXED_MA   12'h190
`define WRB_ILIM_MARGIN_MA  13'h0032

`endif

// ==== design/wrb_pkg.sv ====
// shared state types of the backscatter control block
package wrb_pkg;
	typedef enum logic [1:0] {ENC_IDLE = 2'b01, ENC_SEND = 2'b10} wrb_enc_state_t;
	typedef enum logic [2:0] {RCT_DIODE = 3'b001, RCT_HALF = 3'b010, RCT_FULL = 3'b100} wrb_rect_state_t;
	typedef enum logic [1:0] {SNS_READ = 2'b01, SNS_MON = 2'b10} wrb_sense_state_t;
endpackage

// ==== design/wrb_mem_if.sv ====
// packet buffer port bundle between the control core and its buffer memory
`timescale 1ns/1ps
interface wrb_mem_if #(parameter int AW = 4);
	logic          we;
	logic [AW-1:0] waddr;
	logic [7:0]    wdata;
	logic [AW-1:0] raddr;
	logic [7:0]    rdata;
	modport core (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ==== design/wrb_pkt_mem.sv ====
// payload byte buffer with registered read data
`timescale 1ns/1ps
module wrb_pkt_mem
	import wrb_pkg::*;
#(
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	wrb_mem_if.mem   bus
);
	logic [7:0] store_q [DEPTH];

	always_ff @(posedge clk_i) begin
		if (bus.we) begin
			store_q[bus.waddr] <= bus.wdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus.rdata <= 8'h00;
		end else begin
			bus.rdata <= store_q[bus.raddr];
		end
	end
endmodule

// ==== design/wrb_top.sv ====
// backscatter packet encoder, communication current limit, rectifier and sense-pin sequencing
//
// The register offsets and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`include "wrb_defines.svh"

module wrb_top
	import wrb_pkg::*;
#(
	parameter int HALF_BIT_CYC = `WRB_BIT_PERIOD_US * `WRB_CLK_MHZ / 2,
	parameter int READ_CYC     = `WRB_SENSE_READ_MS * 1000 * `WRB_CLK_MHZ,
	parameter int PRIO_CYC     = `WRB_PRIO_PERIOD_MS * 1000 * `WRB_CLK_MHZ,
	parameter int STD_CYC      = `WRB_STD_PERIOD_MS * 1000 * `WRB_CLK_MHZ,
	parameter int DEG_CYC      = `WRB_DEGLITCH_US * `WRB_CLK_MHZ,
	parameter int BUF_DEPTH    = 16
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        supply_select_a_i,
	input  wire logic        supply_select_b_i,
	input  wire logic        rect_above_uvlo_i,
	input  wire logic        load_above_full_threshold_i,
	input  wire logic        load_below_half_threshold_i,
	input  wire logic        sense_hot_i,
	input  wire logic        sense_cold_i,
	input  wire logic        sense_ctrl_high_i,
	input  wire logic        sense_ctrl_low_i,
	input  wire logic        sense_control_pin_i,
	output logic             sense_control_pin_o,
	output logic             sense_control_pin_oe_o,
	output logic             sense_read_strobe_o,
	input  wire logic [11:0] iout_ma_i,
	output logic             mod_switch_a_o,
	output logic             mod_switch_b_o,
	output logic             comm_ilim_en_o,
	output logic      [11:0] comm_ilim_ma_o,
	output logic             rect_half_o,
	output logic             rect_full_o,
	output logic             shutdown_o
);
	localparam int AW = $clog2(BUF_DEPTH);

	wrb_mem_if #(.AW(AW)) mbus ();

	wrb_pkt_mem #(.DEPTH(BUF_DEPTH)) u_mem (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.bus   (mbus)
	);

	// pins and comparators are asynchronous to clk_i
	logic [9:0] meta_q;
	logic [9:0] sync_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= 10'h000;
			sync_q <= 10'h000;
		end else begin
			meta_q <= {sense_control_pin_i, sense_ctrl_low_i, sense_ctrl_high_i, sense_cold_i, sense_hot_i,
				load_below_half_threshold_i, load_above_full_threshold_i, rect_above_uvlo_i,
				supply_select_b_i, supply_select_a_i};
			sync_q <= meta_q;
		end
	end

	// filtered comparators: 0 hot, 1 cold, 2 control high, 3 control low
	logic [3:0] filt_q;
	for (genvar g = 0; g < 4; g++) begin : g_deg
		logic [11:0] cnt_q;
		logic [11:0] cnt_d;
		logic        filt_d;
		always_comb begin
			cnt_d  = 12'h000;
			filt_d = filt_q[g];
			if (sync_q[5+g] != filt_q[g]) begin
				cnt_d = cnt_q + 12'h001;
				if (cnt_q == 12'(DEG_CYC - 1)) begin
					filt_d = sync_q[5+g];
					cnt_d  = 12'h000;
				end
			end
		end
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				cnt_q     <= 12'h000;
				filt_q[g] <= 1'b0;
			end else begin
				cnt_q     <= cnt_d;
				filt_q[g] <= filt_d;
			end
		end
	end

	// register bus and control fields
	logic       ack_q, go_q, rpt_q, prio_q;
	logic       ack_d, go_d, rpt_d, prio_d;
	logic [4:0] len_q, len_d;
	logic [7:0] hdr_q, hdr_d;
	logic [AW-1:0] wp_q, wp_d;
	logic [31:0] rdat_q, rdat_d;
	logic       req, wr_ctrl, wr_buf, clr_sd;
	logic       sd_q, pend_q, creq_q;
	logic [7:0] rsn_q;
	wrb_enc_state_t enc_q;
	wrb_rect_state_t rct_q;
	wrb_sense_state_t sns_q;

	assign req     = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr_ctrl = req & wb_we_i & (wb_adr_i == `WRB_ADR_CTRL);
	assign wr_buf  = req & wb_we_i & (wb_adr_i == `WRB_ADR_BUF) & wb_sel_i[0];
	assign clr_sd  = wr_ctrl & wb_sel_i[0] & wb_dat_i[`WRB_CTRL_SDCLR];

	always_comb begin
		ack_d  = req;
		go_d   = wr_ctrl & wb_sel_i[0] & wb_dat_i[`WRB_CTRL_GO];
		rpt_d  = rpt_q;
		prio_d = prio_q;
		len_d  = len_q;
		hdr_d  = hdr_q;
		wp_d   = go_q ? '0 : wp_q;
		rdat_d = 32'h0000_0000;
		if (wr_ctrl && wb_sel_i[0]) begin
			rpt_d  = wb_dat_i[`WRB_CTRL_REPORT];
			prio_d = wb_dat_i[`WRB_CTRL_PRIO];
		end
		if (wr_ctrl && wb_sel_i[1]) begin
			len_d = wb_dat_i[`WRB_CTRL_LEN_LSB +: 5];
		end
		if (wr_ctrl && wb_sel_i[2]) begin
			hdr_d = wb_dat_i[`WRB_CTRL_HDR_LSB +: 8];
		end
		if (wr_buf) begin
			wp_d = AW'(wp_q + 1'b1);
		end
		if (req && !wb_we_i) begin
			unique case (wb_adr_i)
				`WRB_ADR_CTRL: begin
					rdat_d = {8'h00, hdr_q, 3'b000, len_q, 5'h00, prio_q, rpt_q, enc_q == ENC_SEND};
				end
				`WRB_ADR_STATUS: begin
					rdat_d = {14'h0000, sense_read_strobe_o, comm_ilim_en_o, rsn_q, sync_q[9], rect_full_o,
						rect_half_o, filt_q[1], filt_q[0], creq_q, sd_q, enc_q == ENC_SEND};
				end
				`WRB_ADR_ILIM: begin
					rdat_d = {20'h00000, comm_ilim_ma_o};
				end
				default: begin
					rdat_d = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q  <= 1'b0;
			go_q   <= 1'b0;
			rpt_q  <= 1'b0;
			prio_q <= 1'b0;
			len_q  <= `WRB_LEN_RST;
			hdr_q  <= `WRB_HDR_RST;
			wp_q   <= '0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q  <= ack_d;
			go_q   <= go_d;
			rpt_q  <= rpt_d;
			prio_q <= prio_d;
			len_q  <= len_d;
			hdr_q  <= hdr_d;
			wp_q   <= wp_d;
			rdat_q <= rdat_d;
		end
	end

	assign wb_ack_o    = ack_q;
	assign wb_dat_o    = rdat_q;
	assign mbus.we     = wr_buf;
	assign mbus.waddr  = wp_q;
	assign mbus.wdata  = wb_dat_i[7:0];

	// sense window sequencing
	wrb_sense_state_t sns_d;
	logic [25:0] tmr_q, tmr_d;
	logic        settled, in_read, in_mon, ev_ot, ev_unk;
	assign settled = tmr_q >= 26'(DEG_CYC);
	assign in_read = sns_q == SNS_READ;
	assign in_mon  = sns_q == SNS_MON;
	// temperature in the window, host request outside it
	assign ev_ot   = settled & ((in_read & filt_q[0]) | (in_mon & filt_q[3]));
	assign ev_unk  = settled & ((in_read & filt_q[1]) | (in_mon & filt_q[2]));

	always_comb begin
		sns_d = sns_q;
		tmr_d = 26'(tmr_q + 1'b1);
		unique case (sns_q)
			SNS_READ: begin
				if (tmr_q == 26'(READ_CYC - 1)) begin
					sns_d = SNS_MON;
					tmr_d = 26'h0;
				end
			end
			SNS_MON: begin
				if (tmr_q == (prio_q ? 26'(PRIO_CYC - 1) : 26'(STD_CYC - 1))) begin
					sns_d = SNS_READ;
					tmr_d = 26'h0;
				end
			end
			default: begin
				sns_d = SNS_READ;
				tmr_d = 26'h0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sns_q <= SNS_READ;
			tmr_q <= 26'h0;
		end else begin
			sns_q <= sns_d;
			tmr_q <= tmr_d;
		end
	end

	// the pin is only biased inside the read window, released otherwise
	assign sense_read_strobe_o    = in_read;
	assign sense_control_pin_oe_o = in_read;
	assign sense_control_pin_o    = 1'b1;

	// shutdown and stop-packet request; a new fault wins over a clear in the same cycle
	logic sd_d, pend_d, creq_d;
	logic [7:0] rsn_d;
	logic enc_start;
	always_comb begin
		sd_d   = sd_q;
		pend_d = pend_q;
		creq_d = creq_q;
		rsn_d  = rsn_q;
		if (clr_sd) begin
			sd_d   = 1'b0;
			creq_d = 1'b0;
		end
		if (in_mon && settled && filt_q[2]) begin
			creq_d = 1'b1;
		end
		if (enc_start && pend_q) begin
			pend_d = 1'b0;
		end
		if ((!sd_q || clr_sd) && (ev_ot || ev_unk)) begin
			sd_d   = 1'b1;
			pend_d = 1'b1;
			rsn_d  = ev_ot ? `WRB_RSN_OVERTEMP : `WRB_RSN_UNKNOWN;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sd_q   <= 1'b0;
			pend_q <= 1'b0;
			creq_q <= 1'b0;
			rsn_q  <= `WRB_RSN_UNKNOWN;
		end else begin
			sd_q   <= sd_d;
			pend_q <= pend_d;
			creq_q <= creq_d;
			rsn_q  <= rsn_d;
		end
	end
	assign shutdown_o = sd_q;

	// bi-phase encoder
	function automatic logic [10:0] frame(input logic [7:0] b);
		return {1'b1, ~^b, b, 1'b0};
	endfunction

	wrb_enc_state_t enc_d;
	logic [16:0] hc_q, hc_d;
	logic        half_q, half_d, lvl_q, lvl_d, ept_q, ept_d;
	logic [3:0]  bit_q, bit_d;
	logic [10:0] sh_q, sh_d;
	logic [5:0]  byte_q, byte_d, nb_q, nb_d, pick_idx;
	logic [7:0]  pick;
	logic        pick_ept, tick, char_load;

	assign tick       = hc_q == 17'(HALF_BIT_CYC - 1);
	assign enc_start  = (enc_q == ENC_IDLE) & (pend_q | go_q);
	assign char_load  = (enc_q == ENC_SEND) & tick & half_q & (bit_q == `WRB_CHAR_LAST_BIT) &
		(6'(byte_q + 1'b1) != nb_q);
	assign mbus.raddr = byte_q[AW-1:0];

	always_comb begin
		pick_idx = (enc_q == ENC_IDLE) ? 6'h00 : 6'(byte_q + 1'b1);
		pick_ept = (enc_q == ENC_IDLE) ? pend_q : ept_q;
		if (pick_ept) begin
			if (pick_idx == 6'h00) begin
				pick = `WRB_HDR_EPT;
			end else if (pick_idx == 6'h01) begin
				pick = rsn_q;
			end else begin
				pick = `WRB_HDR_EPT ^ rsn_q;
			end
		end else if (pick_idx == 6'h00) begin
			pick = rpt_q ? `WRB_HDR_REPORT : hdr_q;
		end else begin
			pick = mbus.rdata;
		end
	end

	always_comb begin
		enc_d  = enc_q;
		hc_d   = hc_q;
		half_d = half_q;
		bit_d  = bit_q;
		sh_d   = sh_q;
		byte_d = byte_q;
		nb_d   = nb_q;
		ept_d  = ept_q;
		lvl_d  = lvl_q;
		unique case (enc_q)
			ENC_IDLE: begin
				lvl_d = 1'b0;
				if (enc_start) begin
					// a pending stop packet beats a software request
					enc_d  = ENC_SEND;
					hc_d   = 17'h0;
					half_d = 1'b0;
					bit_d  = 4'h0;
					byte_d = 6'h00;
					ept_d  = pend_q;
					nb_d   = pend_q ? `WRB_EPT_CHARS : 6'({1'b0, len_q} + 1'b1);
					sh_d   = frame(pick);
					lvl_d  = 1'b1;
				end
			end
			ENC_SEND: begin
				hc_d = 17'(hc_q + 1'b1);
				if (tick) begin
					hc_d = 17'h0;
					if (!half_q) begin
						half_d = 1'b1;
						lvl_d  = sh_q[0] ? ~lvl_q : lvl_q;
					end else begin
						half_d = 1'b0;
						lvl_d  = ~lvl_q;
						if (bit_q != `WRB_CHAR_LAST_BIT) begin
							bit_d = 4'(bit_q + 1'b1);
							sh_d  = {1'b0, sh_q[10:1]};
						end else if (char_load) begin
							bit_d  = 4'h0;
							byte_d = 6'(byte_q + 1'b1);
							sh_d   = frame(pick);
						end else begin
							enc_d = ENC_IDLE;
							lvl_d = 1'b0;
						end
					end
				end
			end
			default: begin
				enc_d = ENC_IDLE;
				lvl_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enc_q  <= ENC_IDLE;
			hc_q   <= 17'h0;
			half_q <= 1'b0;
			bit_q  <= 4'h0;
			sh_q   <= 11'h000;
			byte_q <= 6'h00;
			nb_q   <= 6'h00;
			ept_q  <= 1'b0;
			lvl_q  <= 1'b0;
		end else begin
			enc_q  <= enc_d;
			hc_q   <= hc_d;
			half_q <= half_d;
			bit_q  <= bit_d;
			sh_q   <= sh_d;
			byte_q <= byte_d;
			nb_q   <= nb_d;
			ept_q  <= ept_d;
			lvl_q  <= lvl_d;
		end
	end
	assign mod_switch_a_o = lvl_q;
	assign mod_switch_b_o = lvl_q;

	// communication current limit and rectifier mode
	logic        ilim_en_q, ilim_en_d;
	logic [11:0] ilim_q, ilim_d;
	logic [12:0] track;
	wrb_rect_state_t rct_d;
	assign track = {1'b0, iout_ma_i} + `WRB_ILIM_MARGIN_MA;

	always_comb begin
		ilim_en_d = (enc_q == ENC_SEND) & ~sync_q[0] & ~sync_q[1];
		if (iout_ma_i <= `WRB_ILIM_KNEE_MA) begin
			ilim_d = `WRB_ILIM_FIXED_MA;
		end else begin
			ilim_d = track[12] ? 12'hfff : track[11:0];
		end
		rct_d = rct_q;
		unique case (rct_q)
			RCT_DIODE: begin
				if (sync_q[2]) begin
					rct_d = RCT_HALF;
				end
			end
			RCT_HALF: begin
				if (!sync_q[2]) begin
					rct_d = RCT_DIODE;
				end else if (sync_q[3]) begin
					rct_d = RCT_FULL;
				end
			end
			RCT_FULL: begin
				if (!sync_q[2]) begin
					rct_d = RCT_DIODE;
				end else if (sync_q[4]) begin
					rct_d = RCT_HALF;
				end
			end
			default: begin
				rct_d = RCT_DIODE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ilim_en_q <= 1'b0;
			ilim_q    <= `WRB_ILIM_FIXED_MA;
			rct_q     <= RCT_DIODE;
		end else begin
			ilim_en_q <= ilim_en_d;
			ilim_q    <= ilim_d;
			rct_q     <= rct_d;
		end
	end
	assign comm_ilim_en_o = ilim_en_q;
	assign comm_ilim_ma_o = ilim_q;
	assign rect_half_o    = rct_q == RCT_HALF;
	assign rect_full_o    = rct_q == RCT_FULL;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_BIT_PERIOD: assert property (enc_q == ENC_SEND && !tick |=> $stable(lvl_q))
		else $error("switch level moved between half-bit ticks");
	AST_ZERO_ONE_EDGE: assert property (enc_q == ENC_SEND && tick && !half_q && !sh_q[0] |=> $stable(lvl_q))
		else $error("zero bit has a mid-bit transition");
	AST_ONE_TWO_EDGE: assert property (enc_q == ENC_SEND && tick && !half_q && sh_q[0] |=> lvl_q != $past(lvl_q))
		else $error("one bit lacks its mid-bit transition");
	AST_CHAR_FRAME: assert property (char_load |=> bit_q == 4'h0 && !sh_q[0] && sh_q[10])
		else $error("character not framed by start zero and stop one");
	AST_ODD_PARITY: assert property (enc_start |=> ^sh_q[9:1])
		else $error("data plus parity is not odd");
	AST_REPORT_HDR: assert property (enc_start && !pend_q && rpt_q |=> sh_q[8:1] == `WRB_HDR_REPORT)
		else $error("report packet header wrong");
	AST_SWITCH_PAIR: assert property (mod_switch_a_o == mod_switch_b_o)
		else $error("modulation switches disagree");
	AST_ILIM_FIXED: assert property (!$past(rst_i) && $past(iout_ma_i) < `WRB_ILIM_KNEE_MA |-> comm_ilim_ma_o == `WRB_ILIM_FIXED_MA)
		else $error("fixed communication limit wrong");
	AST_ILIM_TRACK: assert property ($past(iout_ma_i) > `WRB_ILIM_KNEE_MA && $past(iout_ma_i) < 12'hf00
		|-> comm_ilim_ma_o == $past(iout_ma_i) + 12'h032)
		else $error("tracking limit not current plus margin");
	AST_ILIM_PACKET: assert property (comm_ilim_en_o |-> $past(enc_q) == ENC_SEND)
		else $error("limit applied outside a packet");
	AST_ILIM_SELECT: assert property (!sync_q[0] && sync_q[1] |=> !comm_ilim_en_o)
		else $error("limit active while disabled by supply select");
	AST_RECT_DIODE: assert property (!sync_q[2] |=> !rect_half_o && !rect_full_o)
		else $error("rectifier switching below lockout");
	AST_RECT_FULL: assert property (rect_half_o && sync_q[2] && sync_q[3] |=> rect_full_o)
		else $error("full rectify not entered above threshold");
	AST_READ_LEN: assert property ($fell(sense_read_strobe_o) |-> $past(tmr_q) == 26'(READ_CYC - 1))
		else $error("read window length wrong");
	AST_PIN_RELEASE: assert property (!sense_read_strobe_o |-> !sense_control_pin_oe_o)
		else $error("pin driven outside read window");
	AST_MON_LEN: assert property ($rose(sense_read_strobe_o)
		|-> $past(tmr_q) == ($past(prio_q) ? 26'(PRIO_CYC - 1) : 26'(STD_CYC - 1)))
		else $error("monitor period length wrong");
	AST_EPT_OT: assert property (!sd_q && in_mon && settled && filt_q[3]
		|=> sd_q && pend_q && rsn_q == `WRB_RSN_OVERTEMP)
		else $error("grounded pin did not raise overtemp stop");
	AST_EPT_UNK: assert property (!sd_q && in_mon && settled && filt_q[2] && !filt_q[3] && !filt_q[0]
		|=> sd_q && rsn_q == `WRB_RSN_UNKNOWN)
		else $error("pulled-up pin did not raise unknown stop");
	AST_IDLE_OPEN: assert property (enc_q == ENC_IDLE && !enc_start |=> !mod_switch_a_o)
		else $error("switches closed while idle");

	COV_REPORT: cover property (enc_start && rpt_q && !pend_q);
	COV_EPT: cover property (enc_start && pend_q);
	COV_FULL: cover property (rect_full_o);
	COV_CTRL_REQ: cover property ($rose(creq_q));
endmodule

// ==== bench/wrb_tx_model.sv ====
// transmitter-side demodulator model that decodes the load-modulation switch levels
`timescale 1ns/1ps
module wrb_tx_model #(
	parameter int HALF = 20
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       sw_a_i,
	input  wire logic       sw_b_i,
	output logic      [7:0] byte_o,
	output logic            byte_stb_o,
	output logic            frame_err_o,
	output logic            pkt_end_o
);
	int          cnt;
	int          nb;
	logic        act;
	logic        h0;
	logic        h1;
	logic [10:0] ch;
	// halves are sampled at their middle, so small edge offsets do not matter
	always @(posedge clk_i) begin
		byte_stb_o <= 1'b0;
		pkt_end_o <= 1'b0;
		frame_err_o <= (sw_a_i !== sw_b_i);
		if (rst_i) begin
			act <= 1'b0;
		end else if (!act) begin
			act <= sw_a_i;
			cnt <= 1;
			nb <= 0;
			h1 <= 1'b0;
		end else begin
			cnt <= (cnt == 2 * HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF / 2) begin
				h0 <= sw_a_i;
				// a missing boundary transition marks the end of the packet
				if (sw_a_i == h1) begin
					act <= 1'b0;
					pkt_end_o <= 1'b1;
				end
			end
			if (cnt == HALF + HALF / 2) begin
				h1 <= sw_a_i;
				ch <= {sw_a_i ^ h0, ch[10:1]};
				nb <= (nb == 10) ? 0 : nb + 1;
				if (nb == 10) begin
					byte_o <= ch[9:2];
					byte_stb_o <= 1'b1;
					// start zero, stop one, odd parity over data and parity
					frame_err_o <= (sw_a_i !== sw_b_i) | ch[1] | !(sw_a_i ^ h0) | !(^ch[10:2]);
				end
			end
		end
	end
endmodule

// ==== bench/wrb_top_test.sv ====
// self-checking bench of the backscatter control block
`timescale 1ns/1ps
module wrb_top_test;
	logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0, wsel = 4'hf;
	logic [31:0] dwr = 32'h0, drd, rd;
	logic        ack, sa = 1'b0, sb = 1'b0, uvlo = 1'b0, afull = 1'b0, bhalf = 1'b0;
	logic        hot = 1'b0, cold = 1'b0, term = 1'b1, fault = 1'b0, chi, clo, pin_i;
	logic        pin_o, pin_oe, strobe, swa, swb, ilen, rh, rf, sd, bstb, ferr, pend;
	logic [11:0] iout = 12'h0c8, ilma;
	logic [7:0]  rbyte;
	logic [7:0]  rxq[$];
	int          bad_count = 0, n_tests = 0, cyc_n = 0, t0;
	initial forever #2.5 clk = ~clk;
	// host three-state driver: 1/0 floats, 1/1 grounds, 0/0 pulls up
	always_comb begin
		chi = !term & !fault;
		clo = term & fault;
		pin_i = pin_oe ? pin_o : chi;
	end
	always @(posedge clk) begin
		cyc_n <= cyc_n + 1;
		if (bstb) rxq.push_back(rbyte);
		if (ferr) chk(1, 0);
	end
	wrb_top #(.HALF_BIT_CYC(20), .READ_CYC(200), .PRIO_CYC(300), .STD_CYC(600), .DEG_CYC(4)) u_wrb_top (
		.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dwr), .wb_dat_o(drd), .wb_ack_o(ack), .supply_select_a_i(sa),
		.supply_select_b_i(sb), .rect_above_uvlo_i(uvlo), .load_above_full_threshold_i(afull),
		.load_below_half_threshold_i(bhalf), .sense_hot_i(hot), .sense_cold_i(cold),
		.sense_ctrl_high_i(chi), .sense_ctrl_low_i(clo), .sense_control_pin_i(pin_i),
		.sense_control_pin_o(pin_o), .sense_control_pin_oe_o(pin_oe), .sense_read_strobe_o(strobe),
		.iout_ma_i(iout), .mod_switch_a_o(swa), .mod_switch_b_o(swb), .comm_ilim_en_o(ilen),
		.comm_ilim_ma_o(ilma), .rect_half_o(rh), .rect_full_o(rf), .shutdown_o(sd));
	wrb_tx_model u_wrb_tx_model (.clk_i(clk), .rst_i(rst), .sw_a_i(swa), .sw_b_i(swb),
		.byte_o(rbyte), .byte_stb_o(bstb), .frame_err_o(ferr), .pkt_end_o(pend));
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// bounded wait; running out counts as a mismatch and ends the run
	task automatic wait_for(ref logic s, input logic v, input int n);
		int i;
		for (i = 0; i < n && s !== v; i++) @(posedge clk);
		if (i == n) begin
			chk(0, 1);
			end_sim();
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dwr <= d;
		sel <= wsel;
		@(posedge clk);
		wait_for(ack, 1'b1, 20);
		rd = drd;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic chk_pkt(input logic [7:0] e[$]);
		wait_for(pend, 1'b1, 4000);
		chk(32'(rxq.size()), 32'(e.size()));
		foreach (e[i]) chk({24'h0, rxq[i]}, {24'h0, e[i]});
		rxq.delete();
	endtask
	task automatic t_reset();
		chk({swa, swb, ilen, rh, rf, sd}, 0);
		chk({strobe, pin_oe, pin_o, ilma}, {3'b111, 12'h190});
	endtask
	task automatic t_report();
		wb(1'b1, 8'h08, 32'h5a);
		wb(1'b1, 8'h08, 32'h81);
		wb(1'b0, 8'h10, 32'h0);
		chk(rd, 0);
		wb(1'b1, 8'h00, 32'h0033_0203);
		wait_for(swa, 1'b1, 20);
		t0 = cyc_n;
		repeat (100) @(posedge clk);
		chk({ilen, ilma}, {1'b1, 12'h190});
		iout <= 12'h1f4;
		repeat (3) @(posedge clk);
		chk(ilma, 12'h226);
		chk_pkt('{8'h04, 8'h5a, 8'h81});
		// 33 back-to-back bits of 40 cycles; each character holds an even count of ones, so the
		// closing drop to idle lands as one more boundary edge of a 34th bit, and the end shows mid first half of the bit after that
		chk(cyc_n - t0, 1371);
		chk({ilen, swa, swb}, 0);
	endtask
	task automatic t_nolim();
		sb <= 1'b1;
		wsel = 4'h6;
		wb(1'b1, 8'h00, 32'h0011_0000);
		// lanes 1 and 2 masked: length and header must keep 0 and 0x11
		wsel = 4'h1;
		wb(1'b1, 8'h00, 32'h00ff_1f01);
		wsel = 4'hf;
		repeat (100) @(posedge clk);
		chk(ilen, 0);
		chk_pkt('{8'h11});
		sa <= 1'b1;
		sb <= 1'b0;
		wb(1'b1, 8'h00, 32'h0011_0001);
		repeat (100) @(posedge clk);
		chk(ilen, 0);
		chk_pkt('{8'h11});
		sa <= 1'b0;
	endtask
	task automatic t_rect();
		uvlo <= 1'b1;
		repeat (6) @(posedge clk);
		chk({rh, rf}, 2'b10);
		afull <= 1'b1;
		repeat (6) @(posedge clk);
		chk({rh, rf}, 2'b01);
		afull <= 1'b0;
		bhalf <= 1'b1;
		repeat (6) @(posedge clk);
		chk({rh, rf}, 2'b10);
	endtask
	task automatic t_sense();
		wait_for(strobe, 1'b1, 1000);
		wait_for(strobe, 1'b0, 1000);
		t0 = cyc_n;
		chk(pin_oe, 0);
		wait_for(strobe, 1'b1, 1000);
		chk(cyc_n - t0, 600);
		t0 = cyc_n;
		wait_for(strobe, 1'b0, 1000);
		chk(cyc_n - t0, 200);
		wsel = 4'h1;
		wb(1'b1, 8'h00, 32'h0000_0004);
		wait_for(strobe, 1'b1, 1000);
		wait_for(strobe, 1'b0, 1000);
		t0 = cyc_n;
		wait_for(strobe, 1'b1, 1000);
		chk(cyc_n - t0, 300);
		wb(1'b1, 8'h00, 32'h0000_0000);
		wsel = 4'hf;
	endtask
	// host request, shutdown, stop packet with the reason, then clear
	task automatic stop_case(input logic tm, input logic ft, input logic [7:0] rsn);
		term <= tm;
		fault <= ft;
		wait_for(sd, 1'b1, 100);
		term <= 1'b1;
		fault <= 1'b0;
		hot <= 1'b0;
		cold <= 1'b0;
		chk_pkt('{8'h02, rsn, 8'h02 ^ rsn});
		wb(1'b0, 8'h04, 32'h0);
		chk(rd[15:8], rsn);
		chk(rd[2], !tm && !ft);
		wb(1'b1, 8'h00, 32'h8);
		repeat (2) @(posedge clk);
		chk(sd, 0);
	endtask
	// each case starts at the head of its window, so the filter settles inside it
	task automatic t_faults();
		wait_for(strobe, 1'b1, 1000);
		wait_for(strobe, 1'b0, 1000);
		stop_case(1'b1, 1'b1, 8'h03);
		wait_for(strobe, 1'b1, 1000);
		wait_for(strobe, 1'b0, 1000);
		stop_case(1'b0, 1'b0, 8'h00);
		wait_for(strobe, 1'b0, 1000);
		wait_for(strobe, 1'b1, 1000);
		hot <= 1'b1;
		stop_case(1'b1, 1'b0, 8'h03);
		wait_for(strobe, 1'b0, 1000);
		wait_for(strobe, 1'b1, 1000);
		cold <= 1'b1;
		stop_case(1'b1, 1'b0, 8'h00);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_report();
		t_nolim();
		t_rect();
		t_sense();
		t_faults();
		end_sim();
	end
endmodule
